// ---- verilog/svdq_pkg.sv ----
// Package: shared constants and carriers for the state vector deque
package svdq_pkg;

   // Operation codes issued by the user datapath, one per cycle
   typedef enum logic [2:0] {
      SVDQ_OP_NONE = 3'h0,
      SVDQ_OP_PUSH_FRONT = 3'h1,
      SVDQ_OP_POP_FRONT = 3'h2,
      SVDQ_OP_PUSH_BACK = 3'h3,
      SVDQ_OP_POP_BACK = 3'h4,
      SVDQ_OP_SHIFT = 3'h5
   } svdq_op_t;

   // Initial-contents styles of the vector
   localparam int SVDQ_INIT_FULL = 0;
   localparam int SVDQ_INIT_EMPTY = 1;
   localparam int SVDQ_INIT_SINGLE = 2;

   // Storage styles
   localparam int SVDQ_MODE_QUEUE = 0;
   localparam int SVDQ_MODE_DELAY = 1;

   // Defaults for the element and capacity
   localparam int SVDQ_DEF_WIDTH = 8;
   localparam int SVDQ_DEF_FRAC = 0;
   localparam int SVDQ_DEF_DEPTH = 8;

   // Reset value of the error flag and of the first-cycle marker
   localparam logic SVDQ_ERR_RST = 1'h0;
   localparam logic SVDQ_FIRST_RST = 1'h1;

   // Error cause carrier
   typedef struct packed {
      logic overflow;
      logic underflow;
   } svdq_err_t;

endpackage : svdq_pkg

// ---- verilog/svdq_quant.sv ----
// Build-time quantisation of one initial value to the element type
`timescale 1ns/1ps
module svdq_quant #(
   parameter int WIDTH = 8,
   parameter int FRAC = 0,
   parameter bit SIGNED_T = 1'b1,
   parameter real VALUE = 0.0
) (
   output logic [WIDTH-1:0] o_value // Quantised constant
);

   // Saturation to the range, then truncation toward minus infinity
   localparam real SCALED = VALUE * (2.0 ** FRAC);
   localparam real MAXV = SIGNED_T ? (2.0 ** (WIDTH - 1)) - 1.0
                                   : (2.0 ** WIDTH) - 1.0;
   localparam real MINV = SIGNED_T ? -(2.0 ** (WIDTH - 1)) : 0.0;
   localparam real CLIP = (SCALED > MAXV) ? MAXV
                        : ((SCALED < MINV) ? MINV : SCALED);
   localparam longint IVAL = longint'($floor(CLIP));

   assign o_value = IVAL[WIDTH-1:0];

endmodule : svdq_quant

// ---- verilog/svdq_store.sv ----
// Element storage: one register per slot with a per-slot next value
`timescale 1ns/1ps
module svdq_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk, // Clock
   input wire logic i_rst_b, // Async reset, active low
   input wire logic i_load, // Load all slots from i_init
   input wire logic [DEPTH*WIDTH-1:0] i_init, // Build-time contents
   input wire logic i_we, // Apply i_next this cycle
   input wire logic [DEPTH*WIDTH-1:0] i_next, // Next contents
   output logic [DEPTH*WIDTH-1:0] o_slots // Current contents
);

   // Reset takes zero; the constant image is loaded on the first edge
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_slot
         always_ff @(posedge i_mclk or negedge i_rst_b)
         begin
            if (!i_rst_b)
               o_slots[g*WIDTH +: WIDTH] <= '0;
            else if (i_load)
               o_slots[g*WIDTH +: WIDTH] <= i_init[g*WIDTH +: WIDTH];
            else if (i_we)
               o_slots[g*WIDTH +: WIDTH] <= i_next[g*WIDTH +: WIDTH];
         end
      end
   endgenerate

endmodule : svdq_store

// ---- verilog/svdq_deque.sv ----
// Persistent state vector used as a bounded double-ended queue
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - First cycle loads every element with its quantised initial value.
// - Later cycles present state held from the previous clock edge.
// - Initial contents are build-time constants, never from inputs.
// - Capacity fixed at build; init full, empty or single element.
// - Element zero is the front; element length minus one the back.
// - Indexed read returns the addressed element, queue unchanged.
// - Indexed write replaces the addressed element, length unchanged.
// - Front query returns element zero; error when empty.
// - Back query returns the last element; error when empty.
// - Push front puts value at zero, shifts others back, length plus one.
// - Pop front drops element zero, shifts others forward, length minus one.
// - Push back writes just past the back, length plus one.
// - Pop back drops the back element, length minus one.
// - Push front or push back while full signals an error.
// - Pop, front or back query while empty signals an error.
// - Shift pushes at the front and drops the back, length unchanged.
// - Full, empty and element count are provided.
// - All reads see state from before this cycle's updates; full, empty and count show the state after.
// - Storage style chosen by use: queue registers or delay line.
// - Delay mode outputs back and shifts input in every cycle.
module svdq_deque #(
   parameter int WIDTH = svdq_pkg::SVDQ_DEF_WIDTH,
   parameter int FRAC = svdq_pkg::SVDQ_DEF_FRAC,
   parameter bit SIGNED_T = 1'b1,
   parameter int DEPTH = svdq_pkg::SVDQ_DEF_DEPTH,
   parameter int INIT_KIND = svdq_pkg::SVDQ_INIT_FULL,
   parameter real INIT_VALUE = 0.0,
   parameter int MODE = svdq_pkg::SVDQ_MODE_QUEUE,
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
   localparam int LW = $clog2(DEPTH + 1)
) (
   input wire logic i_mclk, // 40 MHz clock
   input wire logic i_rst_b, // Async reset, active low
   input wire svdq_pkg::svdq_op_t i_op, // End operation
   input wire logic [WIDTH-1:0] i_din, // Value for push or shift
   input wire logic i_wr_en, // Indexed write enable
   input wire logic [AW-1:0] i_wr_idx, // Indexed write address
   input wire logic [WIDTH-1:0] i_wr_data, // Indexed write value
   input wire logic [AW-1:0] i_rd_idx, // Indexed read address
   input wire logic i_front_rd, // Front query this cycle
   input wire logic i_back_rd, // Back query this cycle
   output logic [WIDTH-1:0] o_rd_data, // Indexed read, next cycle
   output logic [WIDTH-1:0] o_front, // Front element, next cycle
   output logic [WIDTH-1:0] o_back, // Back element, next cycle
   output logic o_full, // Length equals capacity
   output logic o_empty, // Length is zero
   output logic [LW-1:0] o_length, // Element count
   output logic o_ready, // First cycle done
   output svdq_pkg::svdq_err_t o_err_cause, // Cause of last error
   output logic o_error // Sticky error flag
);

   initial
   begin
      if (DEPTH < 2 || WIDTH < 1 || WIDTH > 64 || FRAC < 0 ||
          FRAC > WIDTH)
         $error("svdq_deque: bad width, depth or binary point");
      if (INIT_KIND < 0 || INIT_KIND > 2 || MODE < 0 || MODE > 1)
         $error("svdq_deque: bad init kind or mode");
      if (MODE == svdq_pkg::SVDQ_MODE_DELAY &&
          INIT_KIND != svdq_pkg::SVDQ_INIT_FULL)
         $error("svdq_deque: delay line must start full");
   end

   localparam logic [LW-1:0] CAP = LW'(DEPTH);
   localparam logic [LW-1:0] INIT_LEN =
      (INIT_KIND == svdq_pkg::SVDQ_INIT_FULL) ? LW'(DEPTH) :
      (INIT_KIND == svdq_pkg::SVDQ_INIT_EMPTY) ? LW'(0) : LW'(1);

   logic [WIDTH-1:0] init_elem;
   logic [DEPTH*WIDTH-1:0] init_img;
   logic [DEPTH*WIDTH-1:0] slots;
   logic [DEPTH*WIDTH-1:0] next_d;
   logic [LW-1:0] len_q;
   logic [LW-1:0] len_d;
   logic first_q;
   logic err_now;
   logic ovf;
   logic unf;
   logic upd;
   logic [WIDTH-1:0] elem [DEPTH];

   // Constant image, one slot per entry; no input reaches it
   svdq_quant #(
      .WIDTH(WIDTH),
      .FRAC(FRAC),
      .SIGNED_T(SIGNED_T),
      .VALUE(INIT_VALUE)
   ) u_quant (
      .o_value(init_elem)
   );

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_elem
         assign init_img[g*WIDTH +: WIDTH] = init_elem;
         assign elem[g] = slots[g*WIDTH +: WIDTH];
      end
   endgenerate

   // First-cycle marker: the only cycle in which the image is loaded
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         first_q <= svdq_pkg::SVDQ_FIRST_RST;
      else
         first_q <= 1'b0;
   end

   // Error detection from the pre-update length
   always_comb
   begin
      ovf = 1'b0;
      unf = 1'b0;
      if (!first_q && MODE == svdq_pkg::SVDQ_MODE_QUEUE)
      begin
         case (i_op)
            svdq_pkg::SVDQ_OP_PUSH_FRONT,
            svdq_pkg::SVDQ_OP_PUSH_BACK:
               ovf = (len_q == CAP);
            svdq_pkg::SVDQ_OP_POP_FRONT,
            svdq_pkg::SVDQ_OP_POP_BACK,
            svdq_pkg::SVDQ_OP_SHIFT:
               unf = (len_q == '0);
            default:
               unf = 1'b0;
         endcase
         if ((i_front_rd || i_back_rd) && len_q == '0)
            unf = 1'b1;
         if (i_wr_en && LW'(i_wr_idx) >= len_q)
            ovf = 1'b1;
      end
      err_now = ovf | unf;
   end

   // Next contents: the delay term reads the held slots; queue operations read next_d after the indexed write
   always_comb
   begin
      next_d = slots;
      len_d = len_q;
      upd = 1'b0;
      if (MODE == svdq_pkg::SVDQ_MODE_DELAY)
      begin
         next_d = {slots[(DEPTH-1)*WIDTH-1:0], i_din};
         upd = 1'b1;
      end
      else if (!err_now)
      begin
         if (i_wr_en)
         begin
            next_d[i_wr_idx*WIDTH +: WIDTH] = i_wr_data;
            upd = 1'b1;
         end
         case (i_op)
            svdq_pkg::SVDQ_OP_PUSH_FRONT:
            begin
               next_d = {next_d[(DEPTH-1)*WIDTH-1:0], i_din};
               len_d = len_q + LW'(1);
               upd = 1'b1;
            end
            svdq_pkg::SVDQ_OP_POP_FRONT:
            begin
               next_d = {{WIDTH{1'b0}}, next_d[DEPTH*WIDTH-1:WIDTH]};
               len_d = len_q - LW'(1);
               upd = 1'b1;
            end
            svdq_pkg::SVDQ_OP_PUSH_BACK:
            begin
               next_d[len_q*WIDTH +: WIDTH] = i_din;
               len_d = len_q + LW'(1);
               upd = 1'b1;
            end
            svdq_pkg::SVDQ_OP_POP_BACK:
            begin
               len_d = len_q - LW'(1);
            end
            svdq_pkg::SVDQ_OP_SHIFT:
            begin
               // Slot past the back is don't-care, so a plain shift drops it
               next_d = {next_d[(DEPTH-1)*WIDTH-1:0], i_din};
               upd = 1'b1;
            end
            default:
               len_d = len_q;
         endcase
      end
   end

   // Storage realised as parallel registers for either style
   svdq_store #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_store (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_load(first_q),
      .i_init(init_img),
      .i_we(upd && !first_q),
      .i_next(next_d),
      .o_slots(slots)
   );

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         len_q <= '0;
      else if (first_q)
         len_q <= INIT_LEN;
      else
         len_q <= len_d;
   end

   // Query results register the pre-update state
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rd_data <= '0;
         o_front <= '0;
         o_back <= '0;
      end
      else if (!first_q)
      begin
         o_rd_data <= elem[i_rd_idx];
         o_front <= elem[0];
         o_back <= (len_q == '0) ? '0 : elem[AW'(len_q - LW'(1))];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_full <= 1'b0;
         o_empty <= 1'b1;
         o_length <= '0;
         o_ready <= 1'b0;
      end
      else
      begin
         o_full <= first_q ? (INIT_LEN == CAP) : (len_d == CAP);
         o_empty <= first_q ? (INIT_LEN == '0) : (len_d == '0);
         o_length <= first_q ? INIT_LEN : len_d;
         o_ready <= 1'b1;
      end
   end

   // Sticky: once set only reset clears it
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_error <= svdq_pkg::SVDQ_ERR_RST;
         o_err_cause <= '0;
      end
      else if (err_now)
      begin
         o_error <= 1'b1;
         o_err_cause <= '{overflow: ovf, underflow: unf};
      end
   end

   full_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_full == (len_q == CAP) && o_empty == (len_q == '0))
      else $error("full flag disagrees with length");

   len_hold_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && err_now) |=> (len_q == $past(len_q)))
      else $error("length moved on an error cycle");

   sticky_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_error |=> o_error)
      else $error("error flag dropped without reset");

   push_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == 0 &&
       (i_op == svdq_pkg::SVDQ_OP_PUSH_FRONT ||
        i_op == svdq_pkg::SVDQ_OP_PUSH_BACK))
      |=> (len_q == $past(len_q) + LW'(1)))
      else $error("push did not add one");

   pop_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == 0 &&
       (i_op == svdq_pkg::SVDQ_OP_POP_FRONT ||
        i_op == svdq_pkg::SVDQ_OP_POP_BACK))
      |=> (len_q == $past(len_q) - LW'(1)))
      else $error("pop did not remove one");

   push_front_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == 0 &&
       i_op == svdq_pkg::SVDQ_OP_PUSH_FRONT)
      |=> (elem[0] == $past(i_din)))
      else $error("front push value not at slot zero");

   shift_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && i_op == svdq_pkg::SVDQ_OP_SHIFT)
      |=> (len_q == $past(len_q)) ##1 (o_front == $past(i_din, 2)))
      else $error("shift changed length or lost value");

   over_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && MODE == 0 && len_q == CAP &&
       i_op == svdq_pkg::SVDQ_OP_PUSH_BACK)
      |=> o_error && o_err_cause.overflow)
      else $error("push on full not flagged");

   init_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      first_q |=> (len_q == INIT_LEN && elem[0] == init_elem))
      else $error("first cycle did not load init");

   under_flag_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && MODE == svdq_pkg::SVDQ_MODE_QUEUE && len_q == '0 &&
       (i_front_rd || i_back_rd ||
        i_op == svdq_pkg::SVDQ_OP_POP_FRONT ||
        i_op == svdq_pkg::SVDQ_OP_POP_BACK))
      |=> (o_error && o_err_cause.underflow))
      else $error("empty queue access not flagged");

   err_hold_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && err_now) |=> (slots == $past(slots)))
      else $error("contents moved on an error cycle");

   pop_front_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == svdq_pkg::SVDQ_MODE_QUEUE &&
       !i_wr_en && i_op == svdq_pkg::SVDQ_OP_POP_FRONT && len_q > LW'(1))
      |=> (elem[0] == $past(elem[1])))
      else $error("front pop did not move next element up");

   push_back_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == svdq_pkg::SVDQ_MODE_QUEUE &&
       i_op == svdq_pkg::SVDQ_OP_PUSH_BACK)
      |-> ##2 (o_back == $past(i_din, 2)))
      else $error("back push value not shown at the back");

   wr_idx_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && !err_now && MODE == svdq_pkg::SVDQ_MODE_QUEUE &&
       i_wr_en && i_op == svdq_pkg::SVDQ_OP_NONE)
      |=> (elem[$past(i_wr_idx)] == $past(i_wr_data)))
      else $error("indexed write did not land");

   delay_line_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!first_q && MODE == svdq_pkg::SVDQ_MODE_DELAY)
      |=> (elem[0] == $past(i_din)))
      else $error("delay line did not take its input");

endmodule : svdq_deque

// ---- verification/svdq_user.sv ----
// User datapath model that issues queue operations to the deque
`timescale 1ns/1ps
module svdq_user (
   input wire logic i_mclk, // Clock
   input wire logic i_empty, // Queue empty flag from the deque
   output svdq_pkg::svdq_op_t o_op, // End operation
   output logic [7:0] o_din, // Push or shift value
   output logic o_wr_en, // Indexed write enable
   output logic [1:0] o_wr_idx, // Indexed write address
   output logic [7:0] o_wr_data, // Indexed write value
   output logic [1:0] o_rd_idx, // Indexed read address
   output logic o_front_rd, // Front query
   output logic o_back_rd // Back query
);
   initial
   begin
      o_op = svdq_pkg::SVDQ_OP_NONE;
      o_din = 8'h00;
      o_wr_en = 1'h0;
      o_wr_idx = 2'h0;
      o_wr_data = 8'h00;
      o_rd_idx = 2'h0;
      o_front_rd = 1'h0;
      o_back_rd = 1'h0;
   end

   // Queries and the update leave together in one cycle; the deque must
   // answer the queries from the state before the update
   task issue(input svdq_pkg::svdq_op_t op, input logic [7:0] din,
      input logic we, input logic [1:0] widx, input logic [7:0] wdata,
      input logic [1:0] ridx, input logic frd, input logic brd);
      @(posedge i_mclk);
      if (op == svdq_pkg::SVDQ_OP_SHIFT && i_empty)
         o_op <= svdq_pkg::SVDQ_OP_NONE;
      else
         o_op <= op;
      o_din <= din;
      o_wr_en <= we;
      o_wr_idx <= widx;
      o_wr_data <= wdata;
      o_rd_idx <= ridx;
      o_front_rd <= frd;
      o_back_rd <= brd;
      @(posedge i_mclk);
      o_op <= svdq_pkg::SVDQ_OP_NONE;
      o_wr_en <= 1'h0;
      o_front_rd <= 1'h0;
      o_back_rd <= 1'h0;
   endtask : issue
endmodule : svdq_user

// ---- verification/tb_state_vector_deque.sv ----
// Self-checking bench for the bounded double-ended state queue
`timescale 1ns/1ps
module tb_state_vector_deque;
   logic i_mclk = 1'h0;
   logic i_rst_b = 1'h0;
   svdq_pkg::svdq_op_t op;
   logic [7:0] din, wr_data, rd_data, front, back, pre_back, dback;
   logic [1:0] wr_idx, rd_idx;
   logic wr_en, frd, brd, full, empty, ready, error;
   logic [2:0] length, one_len;
   svdq_pkg::svdq_err_t cause;
   int failures = 0;
   int comparisons = 0;

   always #12.5 i_mclk = ~i_mclk;

   svdq_user u_user (.i_mclk(i_mclk), .i_empty(empty), .o_op(op),
      .o_din(din), .o_wr_en(wr_en), .o_wr_idx(wr_idx),
      .o_wr_data(wr_data), .o_rd_idx(rd_idx), .o_front_rd(frd),
      .o_back_rd(brd));

   svdq_deque #(.WIDTH(8), .DEPTH(4),
      .INIT_KIND(svdq_pkg::SVDQ_INIT_EMPTY)) dut (.i_mclk(i_mclk),
      .i_rst_b(i_rst_b), .i_op(op), .i_din(din), .i_wr_en(wr_en),
      .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_rd_idx(rd_idx),
      .i_front_rd(frd), .i_back_rd(brd), .o_rd_data(rd_data),
      .o_front(front), .o_back(back), .o_full(full), .o_empty(empty),
      .o_length(length), .o_ready(ready), .o_err_cause(cause),
      .o_error(error));

   // Delay line, full start at a negative value that must truncate down
   svdq_deque #(.WIDTH(8), .FRAC(1), .DEPTH(4), .INIT_VALUE(-1.25),
      .MODE(svdq_pkg::SVDQ_MODE_DELAY)) dut_dly (.i_mclk(i_mclk),
      .i_rst_b(i_rst_b), .i_op(op), .i_din(din), .i_wr_en(wr_en),
      .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_rd_idx(rd_idx),
      .i_front_rd(frd), .i_back_rd(brd), .o_rd_data(), .o_front(),
      .o_back(dback), .o_full(), .o_empty(), .o_length(), .o_ready(),
      .o_err_cause(), .o_error());

   svdq_deque #(.WIDTH(8), .DEPTH(4),
      .INIT_KIND(svdq_pkg::SVDQ_INIT_SINGLE)) dut_one (.i_mclk(i_mclk),
      .i_rst_b(i_rst_b), .i_op(op), .i_din(din), .i_wr_en(wr_en),
      .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_rd_idx(rd_idx),
      .i_front_rd(frd), .i_back_rd(brd), .o_rd_data(), .o_front(),
      .o_back(), .o_full(), .o_empty(), .o_length(one_len), .o_ready(),
      .o_err_cause(), .o_error());

   task final_report;
      if (failures == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task do_reset;
      int n;
      @(posedge i_mclk);
      i_rst_b <= 1'h0;
      repeat (4) @(posedge i_mclk);
      i_rst_b <= 1'h1;
      n = 0;
      while (ready !== 1'h1 && n < 10)
      begin
         @(posedge i_mclk);
         n++;
      end
      #1;
   endtask : do_reset

   // Capture the answer of the request cycle, then the settled state
   task fin;
      #1;
      pre_back = back;
      @(posedge i_mclk);
      #1;
   endtask : fin

   task go(input svdq_pkg::svdq_op_t o, input logic [7:0] d,
      input logic [1:0] r);
      u_user.issue(o, d, 1'h0, 2'h0, 8'h00, r, 1'h0, 1'h0);
      fin;
   endtask : go

   initial
   begin
      fork
         begin
            repeat (5000) @(posedge i_mclk);
            failures++;
            final_report;
         end
      join_none
      do_reset;
      chk(8'(ready), 8'h01);
      chk(8'(empty), 8'h01);
      chk(8'(full), 8'h00);
      chk(8'(length), 8'h00);
      chk(8'(one_len), 8'h01);
      go(svdq_pkg::SVDQ_OP_NONE, 8'h5A, 2'h0);
      chk(dback, 8'hFD);
      repeat (2) @(posedge i_mclk);
      #1;
      chk(dback, 8'h00);
      @(posedge i_mclk);
      #1;
      chk(dback, 8'h5A);
      go(svdq_pkg::SVDQ_OP_PUSH_BACK, 8'h11, 2'h0);
      chk(back, 8'h11);
      chk(8'(length), 8'h01);
      go(svdq_pkg::SVDQ_OP_PUSH_BACK, 8'h22, 2'h0);
      chk(pre_back, 8'h11);
      chk(back, 8'h22);
      go(svdq_pkg::SVDQ_OP_PUSH_BACK, 8'h33, 2'h0);
      chk(8'(length), 8'h03);
      go(svdq_pkg::SVDQ_OP_PUSH_FRONT, 8'h44, 2'h2);
      chk(front, 8'h44);
      chk(rd_data, 8'h22);
      chk(8'(full), 8'h01);
      chk(8'(length), 8'h04);
      go(svdq_pkg::SVDQ_OP_PUSH_BACK, 8'h55, 2'h0);
      chk(8'(error), 8'h01);
      chk(8'(cause), 8'h02);
      chk(8'(length), 8'h04);
      chk(back, 8'h33);
      do_reset;
      chk(8'(error), 8'h00);
      chk(8'(empty), 8'h01);
      for (int i = 1; i < 4; i++)
         go(svdq_pkg::SVDQ_OP_PUSH_BACK, 8'(i), 2'h0);
      u_user.issue(svdq_pkg::SVDQ_OP_NONE, 8'h00, 1'h1, 2'h1, 8'h77, 2'h1,
         1'h0, 1'h0);
      fin;
      chk(rd_data, 8'h77);
      chk(8'(length), 8'h03);
      go(svdq_pkg::SVDQ_OP_SHIFT, 8'h09, 2'h0);
      chk(front, 8'h09);
      chk(back, 8'h77);
      chk(8'(length), 8'h03);
      go(svdq_pkg::SVDQ_OP_POP_FRONT, 8'h00, 2'h0);
      chk(front, 8'h01);
      chk(8'(length), 8'h02);
      go(svdq_pkg::SVDQ_OP_POP_BACK, 8'h00, 2'h0);
      chk(back, 8'h01);
      chk(8'(length), 8'h01);
      go(svdq_pkg::SVDQ_OP_POP_BACK, 8'h00, 2'h0);
      chk(8'(empty), 8'h01);
      chk(8'(error), 8'h00);
      // Front query, back query and a pop, each against an empty queue
      for (int k = 0; k < 3; k++)
      begin
         u_user.issue((k == 2) ? svdq_pkg::SVDQ_OP_POP_FRONT :
            svdq_pkg::SVDQ_OP_NONE, 8'h00, 1'h0, 2'h0, 8'h00, 2'h0,
            (k == 0), (k == 1));
         fin;
         chk(8'(error), 8'h01);
         chk(8'(cause), 8'h01);
         chk(8'(length), 8'h00);
         do_reset;
      end
      final_report;
   end
endmodule : tb_state_vector_deque
